// [ecc_pkg.sv]
// Package for the event capture and compare channel: register map and fields.
// Assumes a 32-bit AHB-Lite register bus and word-aligned registers.
package ecc_pkg;
  localparam int TIMER_W = 16;
  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_TIME = 8'h04;
  localparam logic [7:0] OFF_PEND = 8'h08;
  localparam logic [7:0] OFF_TIMER = 8'h0c;
  localparam logic [7:0] OFF_COMPARE = 8'h10;
  // channel_control_register fields
  localparam int CTL_OVERWRITE = 0;
  localparam int CTL_CAP_EN = 1;
  localparam int CTL_RISE = 2;
  localparam int CTL_FALL = 3;
  localparam int CTL_CMP_EN = 4;
  localparam int CTL_RESET_TMR = 5;
  localparam int CTL_OVR_IE = 6;
  localparam int CTL_DIR_DOWN = 7;
  localparam int CTL_W = 8;
  localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;
  // capture_pending_flags fields (write one to clear)
  localparam int PND_CAPTURE = 0;
  localparam int PND_OVERRUN = 1;
  localparam int PND_MATCH = 2;
  localparam int PND_W = 3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {ECC_EMPTY, ECC_ONE, ECC_TWO} ecc_fill_e;
endpackage : ecc_pkg

// [ecc_channel.sv]
// Event capture and compare channel with its own timer, AHB-Lite slave.
// Assumes single-word AHB-Lite transfers; capture input synchronous to sys_clk.
//
// Function
// R1: Timer write versus channel reset: reset wins here
// R2: Software avoids writing timer under channel reset
// R3: Match only when timer counts onto compare
// R4: Reset to zero never matches compare zero
// R5: Two-stage store; time read pulls buffer forward
// R6: Transfer into time register empties buffer
// R7: Capture pending set by transfer, not edge
// R8: Overwrite set: overrun replaces older data
// R9: Overwrite clear and both full: ignore edges
// R10: Overrun sets overrun pending flag
// R11: Overrun interrupt distinct, gated by enable
// R12: Overrun means edge finds unconsumed data
// R13: Software keeps an overrun strategy
// R14: Service code rechecks pending before return
// R15: Valid edge latches timer into free stage
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module ecc_channel
  import ecc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic captureIn,
  output logic captureIrq,
  output logic overrunIrq,
  output logic matchIrq
);
  // ------------------------------------------------------------
  // Bus address phase
  // ------------------------------------------------------------
  logic apWrite;
  logic [7:0] apAddr;
  wire addrValid = hsel && hready && (htrans == HTRANS_NONSEQ);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      apWrite <= 1'b0;
      apAddr <= 8'h00;
    end else begin
      apWrite <= addrValid && hwrite;
      apAddr <= haddr;
    end
  end
  // ------------------------------------------------------------
  // Registers and decode
  // ------------------------------------------------------------
  logic [CTL_W-1:0] control;
  logic [TIMER_W-1:0] timer, compareVal, timeReg, bufReg, prevTimer;
  logic [PND_W-1:0] pend;
  logic timeFull, bufFull, prevIn, prevValid;
  wire wrCtl = apWrite && (apAddr == OFF_CONTROL);
  wire wrPend = apWrite && (apAddr == OFF_PEND);
  wire wrTimer = apWrite && (apAddr == OFF_TIMER);
  wire wrCmp = apWrite && (apAddr == OFF_COMPARE);
  wire rdTime = addrValid && !hwrite && (haddr == OFF_TIME);
  // ------------------------------------------------------------
  // Edge detection and capture store
  // ------------------------------------------------------------
  wire riseEdge = captureIn && !prevIn && control[CTL_RISE];
  wire fallEdge = !captureIn && prevIn && control[CTL_FALL];
  wire validEdge = control[CTL_CAP_EN] && (riseEdge || fallEdge);
  // Both stages still hold unconsumed data when a new edge arrives and no time read frees one
  wire overrun = validEdge && timeFull && bufFull && !rdTime; // R12
  wire overwrite = control[CTL_OVERWRITE];
  // Read of the time register pulls the buffer forward
  wire transfer = rdTime && bufFull; // R5
  wire resetTimer = validEdge && control[CTL_RESET_TMR];
  ecc_fill_e fill;
  assign fill = (timeFull && bufFull) ? ECC_TWO : (timeFull ? ECC_ONE : ECC_EMPTY);

  logic [TIMER_W-1:0] next_timeReg, next_bufReg;
  logic next_timeFull, next_bufFull, loadTime;
  always_comb begin
    next_timeReg = timeReg;
    next_bufReg = bufReg;
    next_timeFull = timeFull;
    next_bufFull = bufFull;
    loadTime = 1'b0;
    if (transfer) begin
      next_timeReg = bufReg; // R5
      next_bufFull = 1'b0; // R6
      loadTime = 1'b1;
    end else if (rdTime) begin
      next_timeFull = 1'b0;
    end
    if (validEdge) begin
      case (fill)
        ECC_EMPTY: begin
          next_timeReg = timer; // R15
          next_timeFull = 1'b1;
          loadTime = 1'b1;
        end
        ECC_ONE: begin
          if (rdTime) begin
            next_timeReg = timer; // R15
            next_timeFull = 1'b1;
            loadTime = 1'b1;
          end else begin
            next_bufReg = timer; // R15
            next_bufFull = 1'b1;
          end
        end
        ECC_TWO: begin
          if (rdTime || overwrite) begin
            next_bufReg = timer; // R8
            next_bufFull = 1'b1;
          end else begin
            // Overwrite clear: edge dropped while both stages hold data
            next_bufReg = bufReg; // R9
          end
        end
        default: begin
          next_bufFull = bufFull; // R9
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Timer and compare
  // ------------------------------------------------------------
  wire [TIMER_W-1:0] countNext = control[CTL_DIR_DOWN] ? timer - 16'h0001 : timer + 16'h0001;
  // Only a counted step onto the value matches; loads and resets do not
  wire counted = prevValid && (timer == compareVal) && (prevTimer != timer); // R3
  wire match = control[CTL_CMP_EN] && counted; // R4

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      control <= CTL_RESET;
      timer <= 16'h0000;
      compareVal <= 16'h0000;
      timeReg <= 16'h0000;
      bufReg <= 16'h0000;
      timeFull <= 1'b0;
      bufFull <= 1'b0;
      pend <= 3'h0;
      prevIn <= 1'b0;
      prevTimer <= 16'h0000;
      prevValid <= 1'b0;
    end else begin
      prevIn <= captureIn;
      if (wrCtl) begin
        control <= hwdata[CTL_W-1:0];
      end
      if (wrCmp) begin
        compareVal <= hwdata[TIMER_W-1:0];
      end
      // Channel reset takes precedence over a coincident write
      if (resetTimer) begin
        timer <= 16'h0000; // R1
        prevValid <= 1'b0; // R4
      end else if (wrTimer) begin
        timer <= hwdata[TIMER_W-1:0];
        prevValid <= 1'b0; // R3
      end else begin
        timer <= countNext;
        prevValid <= 1'b1;
      end
      prevTimer <= timer;
      timeReg <= next_timeReg;
      bufReg <= next_bufReg;
      timeFull <= next_timeFull;
      bufFull <= next_bufFull;
      // Hardware set wins over a same-cycle write-one-to-clear
      pend[PND_CAPTURE] <= loadTime || (pend[PND_CAPTURE] && !(wrPend && hwdata[PND_CAPTURE])); // R7
      pend[PND_OVERRUN] <= overrun || (pend[PND_OVERRUN] && !(wrPend && hwdata[PND_OVERRUN])); // R10
      pend[PND_MATCH] <= match || (pend[PND_MATCH] && !(wrPend && hwdata[PND_MATCH]));
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic [31:0] next_hrdata;
  always_comb begin
    next_hrdata = 32'h0000_0000;
    case (haddr)
      OFF_CONTROL: next_hrdata = {24'h000000, control};
      OFF_TIME: next_hrdata = {16'h0000, timeReg};
      OFF_PEND: next_hrdata = {29'h0, pend};
      OFF_TIMER: next_hrdata = {16'h0000, timer};
      OFF_COMPARE: next_hrdata = {16'h0000, compareVal};
      default: next_hrdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      captureIrq <= 1'b0;
      overrunIrq <= 1'b0;
      matchIrq <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrValid && !hwrite) begin
        hrdata <= next_hrdata;
      end
      captureIrq <= loadTime; // R7
      overrunIrq <= overrun && control[CTL_OVR_IE]; // R11
      matchIrq <= match;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_drop;
    validEdge && fill == ECC_TWO && !overwrite && !rdTime;
  endsequence
  sequence s_edge_one;
    validEdge && fill == ECC_ONE && !rdTime;
  endsequence
  sequence s_read_clash;
    validEdge && fill == ECC_TWO && rdTime;
  endsequence
  sequence s_overrun_on;
    overrun && control[CTL_OVR_IE];
  endsequence
  // Undisturbed count step that lands on the compare value
  sequence s_count_onto;
    control[CTL_CMP_EN] && !wrCtl && !wrCmp && !resetTimer && !wrTimer
      && countNext == compareVal;
  endsequence
  a_capture_flag_transfer: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
    transfer |=> pend[PND_CAPTURE] && captureIrq)
    else $error("transfer did not set capture pending");
  a_transfer_empties_buf: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
    transfer && !validEdge |=> !bufFull)
    else $error("buffer not emptied by transfer");
  a_transfer_moves_data: assert property (@(posedge sys_clk) disable iff (!rst_b) // R5
    transfer && !validEdge |=> timeReg == $past(bufReg))
    else $error("buffer value not moved");
  a_drop_keeps_buf: assert property (@(posedge sys_clk) disable iff (!rst_b) // R9
    s_drop |=> $stable(bufReg) && $stable(timeReg))
    else $error("edge stored while full without overwrite");
  a_overwrite_replaces: assert property (@(posedge sys_clk) disable iff (!rst_b) // R8
    validEdge && fill == ECC_TWO && overwrite |=> bufReg == $past(timer))
    else $error("overwrite did not replace data");
  a_overrun_pending: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
    overrun |=> pend[PND_OVERRUN])
    else $error("overrun pending not set");
  a_overrun_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
    overrunIrq |-> $past(overrun) && $past(control[CTL_OVR_IE]))
    else $error("overrun interrupt without cause");
  a_no_match_reset: assert property (@(posedge sys_clk) disable iff (!rst_b) // R4
    resetTimer |=> !match)
    else $error("timer reset produced a match");
  a_capture_empty: assert property (@(posedge sys_clk) disable iff (!rst_b) // R15
    validEdge && fill == ECC_EMPTY && !rdTime |=> timeFull && timeReg == $past(timer))
    else $error("edge not captured into empty stage");
  // ------------------------------------------------------------
  // Store checks
  // ------------------------------------------------------------
  a_edge_buffer_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
    s_edge_one |=> !captureIrq)
    else $error("edge into buffer raised capture interrupt");
  a_idle_no_load: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
    !validEdge && !transfer |=> !captureIrq)
    else $error("capture interrupt without a load");
  a_read_clash_flags: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
    s_read_clash |=> timeFull && bufFull && pend[PND_CAPTURE])
    else $error("read at edge left store without pending");
  a_edge_into_buffer: assert property (@(posedge sys_clk) disable iff (!rst_b) // R15
    s_edge_one |=> bufFull && bufReg == $past(timer))
    else $error("edge not captured into buffer");
  a_store_order: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
    bufFull |-> timeFull)
    else $error("buffer holds data ahead of time register");
  a_time_read_empties: assert property (@(posedge sys_clk) disable iff (!rst_b) // R5
    rdTime && !bufFull && !validEdge |=> !timeFull)
    else $error("time read did not empty the store");
  a_drop_no_flag: assert property (@(posedge sys_clk) disable iff (!rst_b) // R9
    s_drop |=> !captureIrq && bufFull)
    else $error("dropped edge raised capture interrupt");
  a_overrun_cause: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
    $rose(pend[PND_OVERRUN]) |-> $past(validEdge && bufFull))
    else $error("overrun pending without unconsumed data");
  a_overrun_irq_fires: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
    s_overrun_on |=> overrunIrq)
    else $error("enabled overrun gave no interrupt");
  a_overrun_irq_masked: assert property (@(posedge sys_clk) disable iff (!rst_b) // R11
    overrun && !control[CTL_OVR_IE] |=> !overrunIrq)
    else $error("masked overrun raised interrupt");
  // ------------------------------------------------------------
  // Timer and compare checks
  // ------------------------------------------------------------
  a_reset_beats_write: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
    resetTimer |=> timer == 16'h0000)
    else $error("channel reset lost to timer write");
  a_load_no_match: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
    wrTimer && !resetTimer |=> !match)
    else $error("timer load produced a match");
  a_count_hits: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
    s_count_onto |=> match)
    else $error("count onto compare value missed");
  a_match_flags: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
    match |=> matchIrq && pend[PND_MATCH])
    else $error("match did not set pending and interrupt");
  a_reset_no_irq: assert property (@(posedge sys_clk) disable iff (!rst_b) // R4
    resetTimer |-> ##2 !matchIrq)
    else $error("timer reset raised match interrupt");
endmodule : ecc_channel

// [ecc_edge_src.sv]
// Edge source standing in for the external signal on the capture pin.
// Assumes toggle requests come as one-cycle pulses synchronous to sys_clk.
`timescale 1ns/1ps
module ecc_edge_src (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic toggleReq,
  output logic captureIn
);
  // Each request flips the pin, so every request is one rising or falling edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) captureIn <= 1'b0;
    else if (toggleReq) captureIn <= ~captureIn;
  end
endmodule : ecc_edge_src

// [event_capture_compare_channel_bench.sv]
// Self-checking bench for the capture and compare channel.
// Assumes zero-wait AHB-Lite slave and the edge source model.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module event_capture_compare_channel_bench;
  import ecc_pkg::*;
  logic sys_clk = 0;
  logic rst_b = 0;
  logic hwrite = 0;
  logic toggleReq = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] r1, r2;
  logic [15:0] d;
  wire hready, hresp, captureIn, captureIrq, overrunIrq, matchIrq;
  wire [31:0] hrdata;
  int err_count, compares, capCount, ovrCount, matchCount, c0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    capCount += (captureIrq === 1'b1);
    ovrCount += (overrunIrq === 1'b1);
    matchCount += (matchIrq === 1'b1);
  end
  ecc_edge_src src (.sys_clk(sys_clk), .rst_b(rst_b), .toggleReq(toggleReq),
    .captureIn(captureIn));
  ecc_channel dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .captureIn(captureIn),
    .captureIrq(captureIrq), .overrunIrq(overrunIrq), .matchIrq(matchIrq));
  // ------------------------------
  // Bus and stimulus tasks
  // ------------------------------
  task automatic tally_and_finish;
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_count++;
        tally_and_finish();
      end
      @(posedge sys_clk);
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dw,
                      output logic [31:0] r);
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= dw;
    wait_rdy();
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] dw);
    logic [31:0] x;
    xfer(1'b1, a, dw, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic edges(input int gap);
    toggleReq <= 1'b1;
    @(posedge sys_clk);
    toggleReq <= 1'b0;
    repeat (gap - 1) @(posedge sys_clk);
  endtask : edges
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic sc_two_stage;
    wr(OFF_CONTROL, 32'h0e);
    c0 = capCount;
    edges(10);
    edges(10);
    `CHK(capCount - c0, 1)
    rd(OFF_PEND, r1);
    `CHK(r1, 32'h1)
    wr(OFF_PEND, 32'h1);
    rd(OFF_PEND, r1);
    `CHK(r1, 32'h0)
    rd(OFF_TIME, r1);
    rd(OFF_PEND, r2);
    `CHK(r2, 32'h1)
    rd(OFF_TIME, r2);
    `CHK(r2[15:0] - r1[15:0], 16'd10)
  endtask : sc_two_stage
  task automatic sc_ignore;
    wr(OFF_PEND, 32'h7);
    c0 = ovrCount;
    repeat (3) edges(10);
    rd(OFF_PEND, r1);
    `CHK(r1, 32'h3)
    `CHK(ovrCount - c0, 0)
    rd(OFF_TIME, r1);
    rd(OFF_TIME, r2);
    `CHK(r2[15:0] - r1[15:0], 16'd10)
  endtask : sc_ignore
  task automatic sc_overwrite;
    wr(OFF_CONTROL, 32'h4f);
    wr(OFF_PEND, 32'h7);
    c0 = ovrCount;
    edges(10);
    edges(20);
    edges(10);
    rd(OFF_PEND, r1);
    `CHK(r1[PND_OVERRUN], 1'b1)
    `CHK(ovrCount - c0, 1)
    rd(OFF_TIME, r1);
    rd(OFF_TIME, r2);
    d = r2[15:0] - r1[15:0];
    `CHK(d, 16'd30)
  endtask : sc_overwrite
  task automatic sc_compare;
    wr(OFF_CONTROL, 32'h3e);
    wr(OFF_COMPARE, 32'h0);
    c0 = matchCount;
    edges(20);
    `CHK(matchCount - c0, 0)
    wr(OFF_CONTROL, 32'h10);
    wr(OFF_COMPARE, 32'h40);
    wr(OFF_TIMER, 32'h40);
    repeat (20) @(posedge sys_clk);
    `CHK(matchCount - c0, 0)
    wr(OFF_TIMER, 32'h30);
    repeat (30) @(posedge sys_clk);
    `CHK(matchCount - c0, 1)
    rd(OFF_PEND, r1);
    `CHK(r1[PND_MATCH], 1'b1)
    wr(OFF_CONTROL, 32'h90);
    wr(OFF_TIMER, 32'h50);
    repeat (30) @(posedge sys_clk);
    `CHK(matchCount - c0, 2)
  endtask : sc_compare
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(OFF_CONTROL, r1);
    `CHK(r1, {24'h0, CTL_RESET})
    `CHK(hresp, 1'b0)
    sc_two_stage();
    sc_ignore();
    sc_overwrite();
    sc_compare();
    tally_and_finish();
  end
endmodule : event_capture_compare_channel_bench
